//--- core/weld_current_mode_readout.sv
// constant-current mode selection and end-of-sequence readout
`include "weld_readout_consts.svh"
//------------------------------------------------------------
// register map, one aligned 32-bit word each
//------------------------------------------------------------
// 0x00 control, read and write
//    [6:0] mode code, binary
//    [14:8] process output selection
// 0x04 range, read and write
//    [13:0] range in hundredths; 99 means percent
// 0x08 status, read only
//    [0] constant current on
//    [1] coil sensor
//    [2] auto range
//    [3] compensating
//    [4] setpoint read in kA
//    [5] learning run seen
//    [6] alarm valve on
//    [10:8] display code
//    [11] display flashing
// 0x0C learned maximum current, read only
// other addresses answer with an error; writes are dropped
//
// display codes: 0 blank, 1 current, 2 phase, 3 tap up,
// 4 tap down, 5 limit message
//------------------------------------------------------------

module weld_current_mode_readout #(
   parameter int VALVE_CYCLES = `VALVE_ON_MS * (`MCLK_HZ / 1000)
) (
   input wire logic i_mclk,              // 10 MHz clock
   input wire logic i_reset,             // async reset, high
   input wire logic i_psel,              // apb select
   input wire logic i_penable,           // apb enable
   input wire logic i_pwrite,            // apb direction
   input wire logic [7:0] i_paddr,       // apb byte address
   input wire logic [31:0] i_pwdata,     // apb write data
   output logic [31:0] o_prdata,         // apb read data
   output logic o_pready,                // apb ready
   output logic o_pslverr,               // apb error
   input wire logic i_btn_ones,          // panel data ones button
   input wire logic i_btn_tens,          // panel data tens button
   input wire logic i_btn_other,         // any other panel button
   input wire logic i_current_selected,  // panel shows current param
   input wire logic i_seq_start,         // sequence initiated pulse
   input wire logic i_seq_end,           // sequence ended pulse
   input wire logic i_weld_made,         // weld current flowed
   input wire logic [15:0] i_rms_current, // measured average rms
   input wire logic [7:0] i_phase_pct,   // phase shift firing percent
   input wire logic i_out_low,           // output insufficient
   input wire logic i_out_high,          // output excessive
   input wire logic i_limit_lo,          // below limit window
   input wire logic i_limit_hi,          // above limit window
   input wire logic i_learn_done,        // learning run finished pulse
   output logic [2:0] o_disp_state,      // display content code
   output logic [15:0] o_disp_value,     // value to display
   output logic o_disp_unit_ka,          // value is kiloamperes
   output logic o_disp_flash,            // flash the display
   output logic o_limit_hi,              // limit message is high
   output logic o_tap_down_indicator,    // tap-down message shown
   output logic o_valve3,                // process output valve
   output logic o_comp_active,           // compensation loop enabled
   output logic o_setpoint_ka,           // setpoint read as kA
   output logic o_sensor_secondary       // coil sensor selected
);
   localparam logic [23:0] VALVE_LOAD = 24'(VALVE_CYCLES);
   // reset image of the control word; fields are sliced from it at reset
   localparam logic [31:0] CTRL_INIT = `CTRL_RESET;

   weld_readout_pkg::readout_state_type st_reg;
   weld_readout_pkg::readout_state_type st_next;
   weld_readout_pkg::mode_flags_type flags;
   // filtered panel levels and their rise pulses
   logic [2:0] btn_level;
   logic [2:0] btn_rise;
   logic [1:0] sel_level;
   logic any_btn;
   logic ka_mode;
   logic forced;
   logic show;
   logic limit_fail;
   logic apb_done;

   mode_if mif ();

   //------------------------------------------------------------
   // sub-blocks
   //------------------------------------------------------------
   assign mif.code = st_reg.mode;
   assign flags = mif.flags;

   mode_decoder u_mode (
      .i_mclk(i_mclk),
      .i_reset(i_reset),
      .m(mif.decoder)
   );

   // panel buttons cross from the outside world
   pin_sync #(.WIDTH(3)) u_btn (
      .i_mclk(i_mclk),
      .i_reset(i_reset),
      .i_pin({i_btn_other, i_btn_tens, i_btn_ones}),
      .o_level(btn_level),
      .o_rise(btn_rise)
   );

   // current selection is an operator switch, filtered like the buttons
   pin_sync #(.WIDTH(2)) u_sel (
      .i_mclk(i_mclk),
      .i_reset(i_reset),
      .i_pin({1'b0, i_current_selected}),
      .o_level(sel_level),
      .o_rise()
   );

   //------------------------------------------------------------
   // derived terms
   //------------------------------------------------------------
   // kA setpoint modes; monitoring reads percent
   assign ka_mode = flags.cc_en & flags.compensate &
                    (~flags.auto_rng | (st_reg.range != `RANGE_PERCENT));
   // one process output selection against one code
   function automatic logic po_is(input logic [6:0] po, input logic [6:0] code);
      return po == code;
   endfunction

   assign forced = flags.cc_en &
                   (po_is(st_reg.po, `PO_READOUT) | po_is(st_reg.po, `PO_READOUT_VALVE));
   assign show = forced | (flags.cc_en & sel_level[0]);
   // a limit miss counts only when the readout is forced
   assign limit_fail = forced & (i_limit_lo | i_limit_hi);
   // any new press drops the limit message
   assign any_btn = |btn_rise;
   // a transfer ends on the edge that sees our own ready
   assign apb_done = i_psel & i_penable & st_reg.pready;

   //------------------------------------------------------------
   // next state
   //------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.pready = 1'b0;
      st_next.pslverr = 1'b0;

      // apb: one wait state, then the answer from flops
      // ready lasts one cycle, so back-to-back transfers wait once each
      if (i_psel & i_penable & ~st_reg.pready) begin
         st_next.pready = 1'b1;
         st_next.prdata = 32'h0000_0000;
         case (i_paddr)
            `REG_CTRL_ADDR: begin
               st_next.prdata = {17'h0, st_reg.po, 1'b0, st_reg.mode};
            end
            `REG_RANGE_ADDR: begin
               st_next.prdata = {18'h0, st_reg.range};
            end
            `REG_STATUS_ADDR: begin
               st_next.prdata = {20'h0, st_reg.flash, st_reg.disp, 1'b0,
                                 st_reg.valve, st_reg.learned, ka_mode,
                                 flags.compensate, flags.auto_rng,
                                 flags.secondary, flags.cc_en};
            end
            `REG_LEARN_ADDR: begin
               st_next.prdata = {16'h0, st_reg.learn_max};
            end
            default: begin
               st_next.pslverr = 1'b1;
            end
         endcase
      end

      // writes land on the edge that completes the transfer
      if (apb_done & i_pwrite) begin
         case (i_paddr)
            `REG_CTRL_ADDR: begin
               st_next.mode = i_pwdata[`CTRL_MODE_LSB +: 7];
               st_next.po = i_pwdata[`CTRL_PO_LSB +: 7];
            end
            `REG_RANGE_ADDR: begin
               // range is trusted as programmed, not clipped
               st_next.range = i_pwdata[13:0];
            end
            default: begin
            end
         endcase
      end

      // a learning run stores the maximum output current
      if (i_learn_done) begin
         st_next.learned = 1'b1;
         st_next.learn_max = i_rms_current;
      end

      // auto-range waits for learned data; no correction
      st_next.comp_active = flags.cc_en & flags.compensate &
                            (~flags.auto_rng | st_reg.learned);
      st_next.setpoint_ka = ka_mode;

      // display sequencing
      case (st_reg.disp)
         weld_readout_pkg::DISP_IDLE: begin
         end
         weld_readout_pkg::DISP_LIMIT: begin
            if (any_btn) begin
               st_next.disp = weld_readout_pkg::DISP_IDLE;
               // the flashing stops with the message
               st_next.flash = 1'b0;
            end
         end
         default: begin
            // ones phase, tens kA, others clear
            if (btn_rise[2]) begin
               st_next.disp = weld_readout_pkg::DISP_IDLE;
            end else if (btn_rise[0]) begin
               st_next.disp = weld_readout_pkg::DISP_PHASE;
            end else if (btn_rise[1] & st_reg.weld_made & st_reg.unit_ka) begin
               st_next.disp = weld_readout_pkg::DISP_CURRENT;
            end
         end
      endcase

      // a new start clears what was shown
      if (i_seq_start) begin
         st_next.disp = weld_readout_pkg::DISP_IDLE;
         st_next.flash = 1'b0;
      end

      // end after start in one cycle: the result of the weld is kept
      if (i_seq_end & show) begin
         st_next.rms = i_rms_current;
         st_next.phase = i_phase_pct;
         st_next.weld_made = i_weld_made;
         // kA only after a weld in a kA mode
         st_next.unit_ka = ka_mode & i_weld_made;
         st_next.flash = 1'b0;
         if (limit_fail) begin
            // flash low or high limit message
            st_next.disp = weld_readout_pkg::DISP_LIMIT;
            st_next.flash = 1'b1;
            st_next.lim_hi = i_limit_hi;
         end else if (flags.compensate & i_out_low) begin
            st_next.disp = weld_readout_pkg::DISP_TAP_UP;
         end else if (flags.compensate & i_out_high) begin
            st_next.disp = weld_readout_pkg::DISP_TAP_DOWN;
         end else begin
            st_next.disp = weld_readout_pkg::DISP_CURRENT;
         end
      end

      // valve three on for the fixed alarm time
      // 24 bits hold half a second at the system clock
      if (st_reg.vcnt != 24'h000000) begin
         st_next.vcnt = st_reg.vcnt - 24'h000001;
      end
      if (i_seq_end & limit_fail & po_is(st_reg.po, `PO_READOUT_VALVE)) begin
         st_next.vcnt = VALVE_LOAD;
      end
      st_next.valve = (st_next.vcnt != 24'h000000);

      // display outputs come from flops so the panel sees no decode glitch
      st_next.disp_value = (st_next.disp == weld_readout_pkg::DISP_PHASE) ?
                           {8'h00, st_next.phase} : st_next.rms;
      st_next.tap_dn = (st_next.disp == weld_readout_pkg::DISP_TAP_DOWN);
   end

   //------------------------------------------------------------
   // state register
   //------------------------------------------------------------
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         st_reg <= '0;
         // constants only, so the reset stays a clean asynchronous load
         st_reg.mode <= CTRL_INIT[`CTRL_MODE_LSB +: 7];
         st_reg.po <= CTRL_INIT[`CTRL_PO_LSB +: 7];
         st_reg.range <= `RANGE_RESET;
         st_reg.disp <= weld_readout_pkg::DISP_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end

   //------------------------------------------------------------
   // outputs straight from the state register, except the coil sensor from the decoder flags
   //------------------------------------------------------------
   assign o_prdata = st_reg.prdata;
   assign o_pready = st_reg.pready;
   assign o_pslverr = st_reg.pslverr;
   assign o_disp_state = st_reg.disp;
   assign o_disp_value = st_reg.disp_value;
   assign o_disp_unit_ka = st_reg.unit_ka;
   assign o_disp_flash = st_reg.flash;
   assign o_limit_hi = st_reg.lim_hi;
   assign o_tap_down_indicator = st_reg.tap_dn;
   assign o_valve3 = st_reg.valve;
   assign o_comp_active = st_reg.comp_active;
   assign o_setpoint_ka = st_reg.setpoint_ka;
   assign o_sensor_secondary = flags.secondary;
endmodule

//--- core/weld_readout_consts.svh
// constants for the constant-current mode and readout block
//------------------------------------------------------------
//------------------------------------------------------------
`ifndef WELD_READOUT_CONSTS_SVH
`define WELD_READOUT_CONSTS_SVH
`define REG_CTRL_ADDR 8'h00
`define REG_RANGE_ADDR 8'h04
`define REG_STATUS_ADDR 8'h08
`define REG_LEARN_ADDR 8'h0C
`define CTRL_MODE_LSB 0
`define CTRL_PO_LSB 8
`define CTRL_RESET 32'h0000_0000
`define RANGE_RESET 14'h0000
`define RANGE_PERCENT 14'h0063
`define PO_READOUT 7'h0C
`define PO_READOUT_VALVE 7'h0D
`define MCLK_HZ 10000000
`define VALVE_ON_MS 500
`define VALVE_LINE_CYCLES 30
`endif

//--- core/weld_readout_pkg.sv
// types shared by the constant-current readout modules
package weld_readout_pkg;
   typedef enum logic [2:0] {
      DISP_IDLE, DISP_CURRENT, DISP_PHASE, DISP_TAP_UP, DISP_TAP_DOWN, DISP_LIMIT
   } disp_state_type;

   typedef struct packed {
      logic cc_en;
      logic secondary;
      logic auto_rng;
      logic compensate;
   } mode_flags_type;

   typedef struct packed {
      disp_state_type disp;
      logic flash;
      logic lim_hi;
      logic unit_ka;
      logic [15:0] rms;
      logic [7:0] phase;
      logic weld_made;
      logic valve;
      logic [23:0] vcnt;
      logic [6:0] mode;
      logic [6:0] po;
      logic [13:0] range;
      logic learned;
      logic [15:0] learn_max;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic comp_active;
      logic setpoint_ka;
      logic [15:0] disp_value;
      logic tap_dn;
   } readout_state_type;
endpackage

//--- core/mode_if.sv
// carrier between the mode decoder and the readout logic
interface mode_if;
   logic [6:0] code;
   weld_readout_pkg::mode_flags_type flags;
   modport decoder (input code, output flags);
   modport user (output code, input flags);
endinterface

//--- core/mode_decoder.sv
// decodes the two-digit constant-current mode code into flags
module mode_decoder (
   input wire logic i_mclk,   // system clock
   input wire logic i_reset,  // async reset, high
   mode_if.decoder m          // code in, flags out
);
   weld_readout_pkg::mode_flags_type flags_reg;
   weld_readout_pkg::mode_flags_type flags_next;

   // map one code to its flag set
   function automatic weld_readout_pkg::mode_flags_type decode(input logic [6:0] c);
      weld_readout_pkg::mode_flags_type f;
      f = '0;
      case (c)
         7'h0A, 7'h0B: begin
            f = '{1'b1, 1'b0, 1'b1, (c == 7'h0A)};
         end
         7'h0C, 7'h0E, 7'h10, 7'h12, 7'h0D, 7'h0F, 7'h11, 7'h13: begin
            f = '{1'b1, 1'b0, 1'b0, ~c[0]};
         end
         7'h1E, 7'h1F: begin
            f = '{1'b1, 1'b1, 1'b1, ~c[0]};
         end
         7'h20, 7'h21: begin
            f = '{1'b1, 1'b1, 1'b0, ~c[0]};
         end
         default: begin
            f = '0;
         end
      endcase
      return f;
   endfunction

   // registered so the readout sees a clean value
   always_comb begin
      flags_next = decode(m.code);
   end

   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         flags_reg <= '0;
      end else begin
         flags_reg <= flags_next;
      end
   end

   assign m.flags = flags_reg;
endmodule

//--- core/pin_sync.sv
// three-stage synchroniser with agreement filter and rise pulse
module pin_sync #(
   parameter int WIDTH = 4
) (
   input wire logic i_mclk,              // system clock
   input wire logic i_reset,             // async reset, high
   input wire logic [WIDTH-1:0] i_pin,   // raw pins
   output logic [WIDTH-1:0] o_level,     // filtered level
   output logic [WIDTH-1:0] o_rise       // one-cycle rise pulse
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] level;
      logic [WIDTH-1:0] rise;
   } sync_state_type;

   sync_state_type sync_reg;
   sync_state_type sync_next;

   // a change counts only once stages two and three agree
   always_comb begin
      sync_next = sync_reg;
      sync_next.s1 = i_pin;
      sync_next.s2 = sync_reg.s1;
      sync_next.s3 = sync_reg.s2;
      sync_next.rise = '0;
      for (int i = 0; i < WIDTH; i++) begin
         if (sync_reg.s2[i] == sync_reg.s3[i]) begin
            sync_next.level[i] = sync_reg.s3[i];
            sync_next.rise[i] = sync_reg.s3[i] & ~sync_reg.level[i];
         end
      end
   end

   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         sync_reg <= '0;
      end else begin
         sync_reg <= sync_next;
      end
   end

   assign o_level = sync_reg.level;
   assign o_rise = sync_reg.rise;
endmodule

//--- verification/weld_readout_chk.sv
// port checker of the weld current readout block
module weld_readout_chk #(
   parameter int VALVE_CYCLES = 20
) (
   input wire logic i_mclk,               // clock
   input wire logic i_reset,              // reset, high
   input wire logic i_psel,               // apb select
   input wire logic i_penable,            // apb enable
   input wire logic i_seq_start,          // start pulse
   input wire logic i_seq_end,            // end pulse
   input wire logic i_limit_hi,           // above window
   input wire logic o_pready,             // apb ready
   input wire logic [2:0] o_disp_state,   // display code
   input wire logic o_disp_flash,         // flashing
   input wire logic o_limit_hi,           // limit side
   input wire logic o_tap_down_indicator, // tap down shown
   input wire logic o_valve3,             // alarm valve
   input wire logic o_comp_active         // loop enabled
);
   timeunit 1ns;
   timeprecision 1ns;
   int vcnt_reg;
   default clocking dc @(posedge i_mclk);
   endclocking
   default disable iff (i_reset);
   // valve pulse length so far; a counter keeps long pulses cheap to check
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         vcnt_reg <= 0;
      end else begin
         vcnt_reg <= o_valve3 ? vcnt_reg + 1 : 0;
      end
   end
   sequence access_s;
      $rose(i_penable) && i_psel;
   endsequence
   // end-of-sequence displays that only a sequence end may bring up
   sequence shown_s;
      $changed(o_disp_state) && (o_disp_state inside {3'h3, 3'h4, 3'h5});
   endsequence
   //------------------------------------------------------------
   // assertions
   //------------------------------------------------------------
   apb_answer_a: assert property (access_s |=> o_pready)
      else $error("apb access got no ready after one wait state");
   tap_decode_a: assert property (o_tap_down_indicator == (o_disp_state == 3'h4))
      else $error("tap down output disagrees with display");
   tap_comp_a: assert property (shown_s ##0 (o_disp_state inside {3'h3, 3'h4}) |-> o_comp_active)
      else $error("tap indicator outside compensation");
   end_cause_a: assert property (shown_s |-> $past(i_seq_end))
      else $error("end display appeared without sequence end");
   start_clear_a: assert property (i_seq_start && !i_seq_end |=> o_disp_state == 3'h0)
      else $error("new sequence left old display");
   flash_limit_a: assert property (o_disp_flash |-> o_disp_state == 3'h5)
      else $error("flashing without limit message");
   limit_side_a: assert property (shown_s ##0 (o_disp_state == 3'h5) |-> o_limit_hi == $past(i_limit_hi))
      else $error("limit message shows wrong side");
   valve_len_a: assert property ($fell(o_valve3) |-> vcnt_reg == VALVE_CYCLES)
      else $error("valve pulse of wrong length");
endmodule
bind weld_current_mode_readout weld_readout_chk #(.VALVE_CYCLES(VALVE_CYCLES)) i_chk (
   .i_mclk(i_mclk), .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable),
   .i_seq_start(i_seq_start), .i_seq_end(i_seq_end), .i_limit_hi(i_limit_hi),
   .o_pready(o_pready), .o_disp_state(o_disp_state), .o_disp_flash(o_disp_flash),
   .o_limit_hi(o_limit_hi), .o_tap_down_indicator(o_tap_down_indicator),
   .o_valve3(o_valve3), .o_comp_active(o_comp_active)
);

//--- verification/panel_model.sv
// behavioural front panel operator and weld current sensor
module panel_model (
   input wire logic i_mclk,       // clock
   output logic [2:0] o_btn,      // ones, tens, other
   output logic o_csel,           // current selected
   output logic o_start,          // start pulse
   output logic o_end,            // end pulse
   output logic o_learn,          // learning done pulse
   output logic o_made,           // weld made
   output logic [3:0] o_flags,    // lim hi, lim lo, high, low
   output logic [15:0] o_rms,     // rms reading
   output logic [7:0] o_phase     // phase reading
);
   timeunit 1ns;
   timeprecision 1ns;
   //------------------------------------------------------------
   // operator and sensor actions
   //------------------------------------------------------------
   // idle at time zero
   initial begin
      {o_btn, o_csel, o_start, o_end, o_learn, o_made, o_flags} = 12'h000;
      o_rms = 16'h0000;
      o_phase = 8'h00;
   end
   // held long enough to pass the panel filter
   task automatic press(input logic [2:0] b);
      @(posedge i_mclk);
      o_btn <= b;
      repeat (8) @(posedge i_mclk);
      o_btn <= 3'h0;
      repeat (8) @(posedge i_mclk);
   endtask
   task automatic select(input logic v);
      @(posedge i_mclk);
      o_csel <= v;
   endtask
   task automatic start();
      @(posedge i_mclk);
      o_start <= 1'b1;
      @(posedge i_mclk);
      o_start <= 1'b0;
   endtask
   // readings are good only in the end cycle; inverted after so stale use shows
   task automatic finish(input logic [15:0] r, input logic [7:0] p, input logic [3:0] f);
      @(posedge i_mclk);
      o_rms <= r;
      o_phase <= p;
      o_flags <= f;
      o_made <= (r != 16'h0000); // no current, no weld
      o_end <= 1'b1;
      @(posedge i_mclk);
      o_end <= 1'b0;
      o_rms <= ~r;
      o_phase <= ~p;
      o_flags <= ~f;
      o_made <= 1'b0;
   endtask
   task automatic learn(input logic [15:0] r);
      @(posedge i_mclk);
      o_rms <= r;
      o_learn <= 1'b1;
      @(posedge i_mclk);
      o_learn <= 1'b0;
      o_rms <= ~r;
   endtask
endmodule

//--- verification/weld_current_mode_readout_tb.sv
// self-checking bench of the weld current readout block
`include "weld_readout_consts.svh"
module weld_current_mode_readout_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_mclk, i_reset, psel, pen, pwr, pready, perr, rerr;
   logic [7:0] paddr, ph;
   logic [31:0] pwdata, prdata, rdat;
   logic [2:0] btn, dst;
   logic [3:0] fl;
   logic csel, sst, sen, made, ldone, ka, fla, lhi, tdn, v3, comp, spka, sec;
   logic [15:0] rms, dval;
   int err_total, n_checks, cyc;
   //------------------------------------------------------------
   // design and partner
   //------------------------------------------------------------
   weld_current_mode_readout #(.VALVE_CYCLES(20)) i_dut (
      .i_mclk(i_mclk), .i_reset(i_reset), .i_psel(psel), .i_penable(pen),
      .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(perr), .i_btn_ones(btn[2]), .i_btn_tens(btn[1]),
      .i_btn_other(btn[0]), .i_current_selected(csel), .i_seq_start(sst),
      .i_seq_end(sen), .i_weld_made(made), .i_rms_current(rms), .i_phase_pct(ph),
      .i_out_low(fl[0]), .i_out_high(fl[1]), .i_limit_lo(fl[2]), .i_limit_hi(fl[3]),
      .i_learn_done(ldone), .o_disp_state(dst), .o_disp_value(dval),
      .o_disp_unit_ka(ka), .o_disp_flash(fla), .o_limit_hi(lhi),
      .o_tap_down_indicator(tdn), .o_valve3(v3), .o_comp_active(comp),
      .o_setpoint_ka(spka), .o_sensor_secondary(sec));
   panel_model i_panel (.i_mclk(i_mclk), .o_btn(btn), .o_csel(csel), .o_start(sst),
      .o_end(sen), .o_learn(ldone), .o_made(made), .o_flags(fl), .o_rms(rms), .o_phase(ph));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t ns: saw %h want %h", $time, seen, exp);
      end
   endtask
   // one apb transfer; request held until ready is sampled
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge i_mclk);
      psel <= 1'b1;
      pwr <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge i_mclk);
      pen <= 1'b1;
      // ends when ready is seen; only the hang guard ends a wait that never sees it
      do begin
         @(posedge i_mclk);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic ee);
      apb(1'b0, a, 32'h0);
      chk(rdat, e);
      chk(32'(rerr), 32'(ee));
   endtask
   // bounded wait for a display code
   task automatic wait_disp(input logic [2:0] e);
      for (int n = 0; n < 30 && dst !== e; n++) @(posedge i_mclk);
      chk(32'(dst), 32'(e));
   endtask
   task automatic t_regs();
      logic [6:0] mc [18] = '{7'h0A, 7'h0B, 7'h0C, 7'h0D, 7'h0E, 7'h0F, 7'h10, 7'h11,
         7'h12, 7'h13, 7'h1E, 7'h1F, 7'h20, 7'h21, 7'h00, 7'h14, 7'h09, 7'h22};
      logic [4:0] mx [18] = '{5'h0D, 5'h05, 5'h19, 5'h01, 5'h19, 5'h01, 5'h19, 5'h01,
         5'h19, 5'h01, 5'h0F, 5'h07, 5'h1B, 5'h03, 5'h00, 5'h00, 5'h00, 5'h00};
      rd(`REG_CTRL_ADDR, 32'h0, 1'b0);
      rd(`REG_RANGE_ADDR, 32'h0, 1'b0);
      rd(`REG_STATUS_ADDR, 32'h0, 1'b0);
      wr(8'h10, 32'hFFFF_FFFF);
      rd(8'h10, 32'h0, 1'b1);
      rd(`REG_CTRL_ADDR, 32'h0, 1'b0);
      wr(`REG_CTRL_ADDR, 32'h1E);
      repeat (3) @(posedge i_mclk);
      chk(32'(comp), 32'h0);
      i_panel.learn(16'h0456);
      rd(`REG_LEARN_ADDR, 32'h456, 1'b0);
      rd(`REG_STATUS_ADDR, 32'h3F, 1'b0);
      wr(`REG_RANGE_ADDR, 32'(`RANGE_PERCENT));
      rd(`REG_RANGE_ADDR, 32'h63, 1'b0);
      for (int i = 0; i < 18; i++) begin
         wr(`REG_CTRL_ADDR, 32'(mc[i]));
         rd(`REG_STATUS_ADDR, 32'({1'b1, mx[i]}), 1'b0);
         chk(32'({comp, spka, sec}), 32'({mx[i][3], mx[i][4], mx[i][1]}));
      end
   endtask
   task automatic t_disp();
      i_panel.select(1'b1);
      wr(`REG_CTRL_ADDR, 32'h0C);
      i_panel.finish(16'h0123, 8'h4A, 4'h1);
      wait_disp(3'h3);
      repeat (20) @(posedge i_mclk);
      chk(32'({dst, dval}), 32'h3_0123);
      i_panel.press(3'h4);
      wait_disp(3'h2);
      chk(32'(dval), 32'h4A);
      i_panel.press(3'h2);
      wait_disp(3'h1);
      chk(32'({dval, ka}), 32'h0247);
      i_panel.press(3'h1);
      wait_disp(3'h0);
      i_panel.finish(16'h0777, 8'h10, 4'h2);
      wait_disp(3'h4);
      chk(32'(tdn), 32'h1);
      i_panel.finish(16'h0000, 8'h11, 4'h0);
      i_panel.press(3'h4);
      i_panel.press(3'h2);
      chk(32'({dst, ka}), 32'h4);
      i_panel.start();
      wait_disp(3'h0);
      wr(`REG_CTRL_ADDR, 32'h0D);
      i_panel.finish(16'h0222, 8'h20, 4'h1);
      wait_disp(3'h1);
      i_panel.press(3'h2);
      chk(32'({dst, ka}), 32'h2);
      i_panel.press(3'h1);
   endtask
   task automatic t_po();
      int n;
      i_panel.select(1'b0);
      for (int i = 0; i < 2; i++) begin
         wr(`REG_CTRL_ADDR, i ? 32'h0C00 : 32'h0C);
         i_panel.finish(16'h0100, 8'h30, 4'h0);
         repeat (10) @(posedge i_mclk);
         chk(32'(dst), 32'h0);
      end
      wr(`REG_CTRL_ADDR, 32'h0C0C);
      i_panel.finish(16'h0345, 8'h30, 4'h0);
      wait_disp(3'h1);
      chk(32'(dval), 32'h0345);
      i_panel.finish(16'h0100, 8'h30, 4'h4);
      wait_disp(3'h5);
      chk(32'({fla, lhi, v3}), 32'h4);
      i_panel.press(3'h1);
      wr(`REG_CTRL_ADDR, 32'h0D0C);
      i_panel.finish(16'h0100, 8'h30, 4'h8);
      n = 0;
      repeat (60) begin
         @(posedge i_mclk);
         n += (v3 === 1'b1);
      end
      chk(32'(n), 32'h14);
      chk(32'({dst, lhi}), 32'hB);
      i_panel.press(3'h1);
   endtask
   task automatic close_out();
      $display("checks %0d, mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // 10 MHz clock
   initial begin
      i_mclk = 1'b0;
      forever #50 i_mclk = ~i_mclk;
   end
   // reset for eight cycles, then the scenarios
   initial begin
      i_reset = 1'b1;
      {psel, pen, pwr} = 3'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (8) @(posedge i_mclk);
      i_reset <= 1'b0;
      t_regs();
      t_disp();
      t_po();
      close_out();
   end
   // hang guard well above the expected run
   always @(posedge i_mclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         close_out();
      end
   end
endmodule
